// >>> prfi_pkg.sv
// constants, register map and types for the stage input-processing block
package prfi_pkg;

   // register byte offsets on the AXI4-Lite slave
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_DT_A    = 8'h04;
   localparam logic [7:0] OFS_OT_A    = 8'h08;
   localparam logic [7:0] OFS_DT_B    = 8'h0c;
   localparam logic [7:0] OFS_OT_B    = 8'h10;
   localparam logic [7:0] OFS_INCTL_A = 8'h14;
   localparam logic [7:0] OFS_INCTL_B = 8'h18;
   localparam logic [7:0] OFS_STATUS  = 8'h1c;

   // stage control register fields
   localparam int CTRL_RUN_POS   = 0;
   localparam int CTRL_RMODE_POS = 1;

   // input control register fields
   localparam int INC_MODE_POS = 0;
   localparam int INC_POL_POS  = 4;
   localparam int INC_FILT_POS = 5;
   localparam int INC_KILL_POS = 6;
   localparam int INC_SRC_POS  = 7;
   localparam int INC_W        = 8;

   // status register fields
   localparam int ST_CNT_POS   = 0;
   localparam int ST_PHASE_POS = 12;
   localparam int ST_HOLD_POS  = 14;
   localparam int ST_ACT_POS   = 16;
   localparam int ST_RUN_POS   = 18;

   // reset values
   localparam logic [11:0]      LEN_RST   = 12'h001;
   localparam logic [INC_W-1:0] INCTL_RST = 8'h00;

   // filter span in stage-clock cycles
   localparam int FILTER_LEN = 4;

   // input mode codes
   localparam logic [3:0] IM_NONE   = 4'h0;
   localparam logic [3:0] IM_WAIT   = 4'h1;
   localparam logic [3:0] IM_EXEC   = 4'h2;
   localparam logic [3:0] IM_LOOP   = 4'h3;
   localparam logic [3:0] IM_DEACT  = 4'h4;
   localparam logic [3:0] IM_STOPDT = 4'h5;
   localparam logic [3:0] IM_JUMPW  = 4'h6;
   localparam logic [3:0] IM_HALT   = 4'h7;
   localparam logic [3:0] IM_EDGE   = 4'h8;
   localparam logic [3:0] IM_FIXED  = 4'h9;
   localparam logic [3:0] IM_FIXDE  = 4'he;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      RM_ONE_RAMP  = 2'b00,
      RM_TWO_RAMP  = 2'b01,
      RM_FOUR_RAMP = 2'b10,
      RM_CENTERED  = 2'b11
   } prfi_rmode_type;

   typedef enum logic [1:0] {
      PH_DEAD_A = 2'b00,
      PH_ON_A   = 2'b01,
      PH_DEAD_B = 2'b10,
      PH_ON_B   = 2'b11
   } prfi_phase_type;

endpackage

// >>> prfi_top.sv
// dead-time pwm stage with retrigger/fault input processing and AXI4-Lite registers
`timescale 1ns/1ns

// Function
// - halves A and B each own one input path and control register
// - centered mode ignores retrigger events on both inputs
// - two/four ramp: retrigger ends own cycle, starts opposite cycle at once
// - one ramp: retrigger clears stage counter to zero
// - input A can end output A early; input B output B
// - input inactive, level or edge acting; source comparator or pin
// - filter enable inserts four-cycle digital filter, else bypassed
// - async kill bit lets input drop outputs without clock
// - polarity set: rising edge / high level; clear: falling / low
// - two/four ramp: A only in dead/on time A, B in B
// - one ramp: either input acts across whole ramp
// - four-bit mode field: 0 none, 1..9 modes, 14 mode fourteen
// - mode 1 A: drop output A, wait inactive, then dead/on B
// - mode 1 B: drop output B, wait inactive, then dead/on A
// - mode 2 A: drop A, run dead/on B, then wait A inactive
// - mode 2 B: drop B, run dead/on A, then wait B inactive
// - mode 3 A: drop A, repeat dead B, on B, dead A while active
// - mode 3 B: drop B, repeat dead A, on A, dead B while active
// - modes 2 and 3 always finish the opposite sub-cycle
// - mode 7 event halts stage until software sets run bit
// - edge modes accept event only during corresponding on time
module prfi_top #(
   parameter int CNT_W = 12
) (
   input  wire logic        REF_CLK_IN,
   input  wire logic        RESET_N_IN,
   input  wire logic [1:0]  COMPARATOR_IN,
   input  wire logic [1:0]  EXTERNAL_INPUT_PIN_IN,
   output logic             STAGE_OUTPUT_A_OUT,
   output logic             STAGE_OUTPUT_B_OUT,
   input  wire logic [7:0]  S_AXI_AWADDR_IN,
   input  wire logic        S_AXI_AWVALID_IN,
   output logic             S_AXI_AWREADY_OUT,
   input  wire logic [31:0] S_AXI_WDATA_IN,
   input  wire logic [3:0]  S_AXI_WSTRB_IN,
   input  wire logic        S_AXI_WVALID_IN,
   output logic             S_AXI_WREADY_OUT,
   output logic [1:0]       S_AXI_BRESP_OUT,
   output logic             S_AXI_BVALID_OUT,
   input  wire logic        S_AXI_BREADY_IN,
   input  wire logic [7:0]  S_AXI_ARADDR_IN,
   input  wire logic        S_AXI_ARVALID_IN,
   output logic             S_AXI_ARREADY_OUT,
   output logic [31:0]      S_AXI_RDATA_OUT,
   output logic [1:0]       S_AXI_RRESP_OUT,
   output logic             S_AXI_RVALID_OUT,
   input  wire logic        S_AXI_RREADY_IN
);

   localparam int FL = prfi_pkg::FILTER_LEN;

   logic                         run_ff;
   prfi_pkg::prfi_rmode_type     rmode_ff;
   logic [CNT_W-1:0]             len_ff [4];
   logic [prfi_pkg::INC_W-1:0]   inctl_ff [2];
   prfi_pkg::prfi_phase_type     phase_ff;
   prfi_pkg::prfi_phase_type     nxt_phase;
   logic [CNT_W-1:0]             cnt_ff;
   logic [CNT_W-1:0]             nxt_cnt;
   logic [1:0]                   hold_ff;
   logic [1:0]                   nxt_hold;
   logic [1:0]                   pend_ff;
   logic [1:0]                   nxt_pend;
   logic [1:0]                   loop_ff;
   logic [1:0]                   nxt_loop;
   logic [1:0]                   mask_ff;
   logic [1:0]                   nxt_mask;
   logic [FL-1:0]                hist_ff [2];
   logic [1:0]                   filt_ff;
   logic [1:0]                   act_d_ff;
   logic [1:0]                   src;
   logic [1:0]                   act;
   logic [1:0]                   win;
   logic [1:0]                   evt;
   logic [1:0]                   lvl_mask;
   logic [1:0]                   kill;
   logic                         kill_n;
   logic                         stop_req;
   logic                         phase_end;
   logic [CNT_W-1:0]             len_cur;
   logic [7:0]                   awaddr_ff;
   logic [31:0]                  wdata_ff;
   logic [3:0]                   wstrb_ff;
   logic                         do_write;
   logic                         wr_hit;
   logic [31:0]                  rd_data;
   logic                         rd_hit;

   function automatic prfi_pkg::prfi_phase_type next_phase(input prfi_pkg::prfi_phase_type p);
      case (p)
         prfi_pkg::PH_DEAD_A: next_phase = prfi_pkg::PH_ON_A;
         prfi_pkg::PH_ON_A:   next_phase = prfi_pkg::PH_DEAD_B;
         prfi_pkg::PH_DEAD_B: next_phase = prfi_pkg::PH_ON_B;
         default:             next_phase = prfi_pkg::PH_DEAD_A;
      endcase
   endfunction

   function automatic prfi_pkg::prfi_phase_type own_dt(input logic i);
      own_dt = i ? prfi_pkg::PH_DEAD_B : prfi_pkg::PH_DEAD_A;
   endfunction

   function automatic prfi_pkg::prfi_phase_type own_on(input logic i);
      own_on = i ? prfi_pkg::PH_ON_B : prfi_pkg::PH_ON_A;
   endfunction

   function automatic prfi_pkg::prfi_phase_type opp_dt(input logic i);
      opp_dt = i ? prfi_pkg::PH_DEAD_A : prfi_pkg::PH_DEAD_B;
   endfunction

   function automatic prfi_pkg::prfi_phase_type opp_on(input logic i);
      opp_on = i ? prfi_pkg::PH_ON_A : prfi_pkg::PH_ON_B;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (s[b])
         begin
            r[8*b +: 8] = d[8*b +: 8];
         end
      end
      merge = r;
   endfunction

   // input conditioning, one lane per half
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         logic [3:0] m;
         logic       fv;
         logic       pol;
         m        = inctl_ff[i][prfi_pkg::INC_MODE_POS +: 4];
         pol      = inctl_ff[i][prfi_pkg::INC_POL_POS];
         src[i]   = inctl_ff[i][prfi_pkg::INC_SRC_POS] ? EXTERNAL_INPUT_PIN_IN[i]
                                                       : COMPARATOR_IN[i];
         fv       = inctl_ff[i][prfi_pkg::INC_FILT_POS] ? filt_ff[i] : src[i];
         act[i]   = (fv == pol);
         kill[i]  = inctl_ff[i][prfi_pkg::INC_KILL_POS] & (src[i] == pol);
         case (rmode_ff)
            prfi_pkg::RM_ONE_RAMP: win[i] = 1'b1;
            prfi_pkg::RM_CENTERED: win[i] = 1'b1;
            default:               win[i] = (phase_ff == own_dt(i[0]))
                                            || (phase_ff == own_on(i[0]));
         endcase
         case (m)
            prfi_pkg::IM_WAIT, prfi_pkg::IM_EXEC, prfi_pkg::IM_LOOP,
            prfi_pkg::IM_JUMPW:
               evt[i] = act[i] && (rmode_ff != prfi_pkg::RM_CENTERED);
            prfi_pkg::IM_HALT:
               evt[i] = act[i];
            prfi_pkg::IM_EDGE, prfi_pkg::IM_FIXED:
               evt[i] = act[i] && !act_d_ff[i] && (phase_ff == own_on(i[0]))
                        && (rmode_ff != prfi_pkg::RM_CENTERED);
            default:
               evt[i] = 1'b0;
         endcase
         evt[i] = evt[i] && win[i] && run_ff && (hold_ff == 2'b00)
                  && !pend_ff[i] && !loop_ff[i];
         case (m)
            prfi_pkg::IM_DEACT, prfi_pkg::IM_STOPDT:
               lvl_mask[i] = act[i] && win[i];
            prfi_pkg::IM_FIXDE:
               lvl_mask[i] = act[i] && win[i] && (rmode_ff != prfi_pkg::RM_CENTERED);
            default:
               lvl_mask[i] = 1'b0;
         endcase
      end
   end

   // filter needs the full history equal before the output moves
   always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
      begin
         for (int i = 0; i < 2; i++)
         begin
            hist_ff[i] <= '0;
         end
         filt_ff  <= 2'b00;
         act_d_ff <= 2'b00;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            hist_ff[i] <= {hist_ff[i][FL-2:0], src[i]};
            if (&hist_ff[i])
            begin
               filt_ff[i] <= 1'b1;
            end
            else if (~|hist_ff[i])
            begin
               filt_ff[i] <= 1'b0;
            end
         end
         act_d_ff <= act;
      end
   end

   assign len_cur   = len_ff[phase_ff];
   assign phase_end = (len_cur == '0) || (cnt_ff >= len_cur - 1'b1);

   // sequencer: counter, phase and the per-input wait/loop bookkeeping
   always_comb
   begin
      nxt_phase = phase_ff;
      nxt_cnt   = cnt_ff;
      nxt_hold  = hold_ff;
      nxt_pend  = pend_ff;
      nxt_loop  = loop_ff;
      nxt_mask  = mask_ff;
      stop_req  = 1'b0;
      if (run_ff && (hold_ff == 2'b00))
      begin
         if (phase_end)
         begin
            nxt_cnt   = '0;
            nxt_phase = next_phase(phase_ff);
         end
         else
         begin
            nxt_cnt = cnt_ff + 1'b1;
         end
         for (int i = 0; i < 2; i++)
         begin
            if (pend_ff[i] && phase_end && (phase_ff == opp_on(i[0])))
            begin
               nxt_pend[i] = 1'b0;
               nxt_hold[i] = act[i];
            end
            if (loop_ff[i] && phase_end && (phase_ff == own_dt(i[0])))
            begin
               if (act[i])
               begin
                  nxt_phase = opp_dt(i[0]);
               end
               else
               begin
                  nxt_loop[i] = 1'b0;
               end
            end
         end
      end
      for (int i = 0; i < 2; i++)
      begin
         if (hold_ff[i] && !act[i])
         begin
            nxt_hold[i] = 1'b0;
         end
         if (nxt_phase != own_on(i[0]))
         begin
            nxt_mask[i] = 1'b0;
         end
         if (evt[i])
         begin
            case (inctl_ff[i][prfi_pkg::INC_MODE_POS +: 4])
               prfi_pkg::IM_HALT:
                  stop_req = 1'b1;
               prfi_pkg::IM_FIXED:
                  nxt_mask[i] = 1'b1;
               default:
               begin
                  nxt_cnt = '0;
                  nxt_phase = (rmode_ff == prfi_pkg::RM_ONE_RAMP) ? prfi_pkg::PH_DEAD_A
                                                                 : opp_dt(i[0]);
                  case (inctl_ff[i][prfi_pkg::INC_MODE_POS +: 4])
                     prfi_pkg::IM_WAIT, prfi_pkg::IM_JUMPW: nxt_hold[i] = 1'b1;
                     prfi_pkg::IM_EXEC: nxt_pend[i] = 1'b1;
                     prfi_pkg::IM_LOOP: nxt_loop[i] = 1'b1;
                     default:           nxt_hold[i] = 1'b0;
                  endcase
               end
            endcase
         end
      end
   end

   always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
      begin
         phase_ff <= prfi_pkg::PH_DEAD_A;
         cnt_ff   <= '0;
         hold_ff  <= 2'b00;
         pend_ff  <= 2'b00;
         loop_ff  <= 2'b00;
         mask_ff  <= 2'b00;
      end
      else
      begin
         phase_ff <= nxt_phase;
         cnt_ff   <= nxt_cnt;
         hold_ff  <= nxt_hold;
         pend_ff  <= nxt_pend;
         loop_ff  <= nxt_loop;
         mask_ff  <= nxt_mask;
      end
   end

   // kill path is combinational from the selected pin or comparator, so glitches on a killing input drop the outputs
   assign kill_n = RESET_N_IN & ~kill[0] & ~kill[1];

   always_ff @(posedge REF_CLK_IN or negedge kill_n)
   begin
      if (!kill_n)
      begin
         STAGE_OUTPUT_A_OUT <= 1'b0;
         STAGE_OUTPUT_B_OUT <= 1'b0;
      end
      else
      begin
         STAGE_OUTPUT_A_OUT <= run_ff && !stop_req && (nxt_phase == prfi_pkg::PH_ON_A)
                               && (nxt_hold == 2'b00) && !nxt_mask[0] && !lvl_mask[0];
         STAGE_OUTPUT_B_OUT <= run_ff && !stop_req && (nxt_phase == prfi_pkg::PH_ON_B)
                               && (nxt_hold == 2'b00) && !nxt_mask[1] && !lvl_mask[1];
      end
   end

   // AXI4-Lite write channel: address and data taken in either order
   assign do_write = !S_AXI_AWREADY_OUT && !S_AXI_WREADY_OUT && !S_AXI_BVALID_OUT;
   assign wr_hit   = (awaddr_ff[7:2] <= prfi_pkg::OFS_INCTL_B[7:2]);

   always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
      begin
         S_AXI_AWREADY_OUT <= 1'b1;
         S_AXI_WREADY_OUT  <= 1'b1;
         S_AXI_BVALID_OUT  <= 1'b0;
         S_AXI_BRESP_OUT   <= prfi_pkg::RESP_OKAY;
         awaddr_ff         <= 8'h00;
         wdata_ff          <= 32'h0000_0000;
         wstrb_ff          <= 4'h0;
      end
      else
      begin
         if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT)
         begin
            awaddr_ff         <= S_AXI_AWADDR_IN;
            S_AXI_AWREADY_OUT <= 1'b0;
         end
         if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT)
         begin
            wdata_ff         <= S_AXI_WDATA_IN;
            wstrb_ff         <= S_AXI_WSTRB_IN;
            S_AXI_WREADY_OUT <= 1'b0;
         end
         if (do_write)
         begin
            S_AXI_BVALID_OUT <= 1'b1;
            S_AXI_BRESP_OUT  <= wr_hit ? prfi_pkg::RESP_OKAY : prfi_pkg::RESP_SLVERR;
         end
         if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN)
         begin
            S_AXI_BVALID_OUT  <= 1'b0;
            S_AXI_AWREADY_OUT <= 1'b1;
            S_AXI_WREADY_OUT  <= 1'b1;
         end
      end
   end

   // register storage; a software run write beats a same-cycle halt
   always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
      begin
         run_ff   <= 1'b0;
         rmode_ff <= prfi_pkg::RM_ONE_RAMP;
         for (int k = 0; k < 4; k++)
         begin
            len_ff[k] <= prfi_pkg::LEN_RST[CNT_W-1:0];
         end
         for (int i = 0; i < 2; i++)
         begin
            inctl_ff[i] <= prfi_pkg::INCTL_RST;
         end
      end
      else
      begin
         if (do_write && (awaddr_ff[7:2] == prfi_pkg::OFS_CTRL[7:2]) && wstrb_ff[0])
         begin
            run_ff   <= wdata_ff[prfi_pkg::CTRL_RUN_POS];
            rmode_ff <= prfi_pkg::prfi_rmode_type'(wdata_ff[prfi_pkg::CTRL_RMODE_POS +: 2]);
         end
         else if (stop_req)
         begin
            run_ff <= 1'b0;
         end
         for (int k = 0; k < 4; k++)
         begin
            if (do_write && (awaddr_ff[7:2] == 6'(k + 1)))
            begin
               len_ff[k] <= CNT_W'(merge(32'(len_ff[k]), wdata_ff, wstrb_ff));
            end
         end
         for (int i = 0; i < 2; i++)
         begin
            if (do_write && (awaddr_ff[7:2] == 6'(i + 5)) && wstrb_ff[0])
            begin
               inctl_ff[i] <= wdata_ff[prfi_pkg::INC_W-1:0];
            end
         end
      end
   end

   // read mux; unmapped words read zero with SLVERR
   always_comb
   begin
      rd_data = 32'h0000_0000;
      rd_hit  = 1'b1;
      case (S_AXI_ARADDR_IN[7:2])
         prfi_pkg::OFS_CTRL[7:2]:
         begin
            rd_data[prfi_pkg::CTRL_RUN_POS]       = run_ff;
            rd_data[prfi_pkg::CTRL_RMODE_POS +: 2] = rmode_ff;
         end
         prfi_pkg::OFS_DT_A[7:2]:    rd_data[CNT_W-1:0] = len_ff[0];
         prfi_pkg::OFS_OT_A[7:2]:    rd_data[CNT_W-1:0] = len_ff[1];
         prfi_pkg::OFS_DT_B[7:2]:    rd_data[CNT_W-1:0] = len_ff[2];
         prfi_pkg::OFS_OT_B[7:2]:    rd_data[CNT_W-1:0] = len_ff[3];
         prfi_pkg::OFS_INCTL_A[7:2]: rd_data[prfi_pkg::INC_W-1:0] = inctl_ff[0];
         prfi_pkg::OFS_INCTL_B[7:2]: rd_data[prfi_pkg::INC_W-1:0] = inctl_ff[1];
         prfi_pkg::OFS_STATUS[7:2]:
         begin
            rd_data[prfi_pkg::ST_CNT_POS +: CNT_W] = cnt_ff;
            rd_data[prfi_pkg::ST_PHASE_POS +: 2]   = phase_ff;
            rd_data[prfi_pkg::ST_HOLD_POS +: 2]    = hold_ff;
            rd_data[prfi_pkg::ST_ACT_POS +: 2]     = act;
            rd_data[prfi_pkg::ST_RUN_POS]          = run_ff;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
      begin
         S_AXI_ARREADY_OUT <= 1'b1;
         S_AXI_RVALID_OUT  <= 1'b0;
         S_AXI_RDATA_OUT   <= 32'h0000_0000;
         S_AXI_RRESP_OUT   <= prfi_pkg::RESP_OKAY;
      end
      else
      begin
         if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT)
         begin
            S_AXI_ARREADY_OUT <= 1'b0;
            S_AXI_RVALID_OUT  <= 1'b1;
            S_AXI_RDATA_OUT   <= rd_data;
            S_AXI_RRESP_OUT   <= rd_hit ? prfi_pkg::RESP_OKAY : prfi_pkg::RESP_SLVERR;
         end
         else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN)
         begin
            S_AXI_RVALID_OUT  <= 1'b0;
            S_AXI_ARREADY_OUT <= 1'b1;
         end
      end
   end

endmodule

// >>> prfi_checker.sv
// port-level assertions for the stage input block
`timescale 1ns/1ns
module prfi_checker (
   input wire logic        REF_CLK_IN,
   input wire logic        RESET_N_IN,
   input wire logic        STAGE_OUTPUT_A_OUT,
   input wire logic        STAGE_OUTPUT_B_OUT,
   input wire logic [7:0]  S_AXI_AWADDR_IN,
   input wire logic        S_AXI_AWVALID_IN,
   input wire logic        S_AXI_AWREADY_OUT,
   input wire logic        S_AXI_WVALID_IN,
   input wire logic        S_AXI_WREADY_OUT,
   input wire logic [1:0]  S_AXI_BRESP_OUT,
   input wire logic        S_AXI_BVALID_OUT,
   input wire logic        S_AXI_BREADY_IN,
   input wire logic [7:0]  S_AXI_ARADDR_IN,
   input wire logic        S_AXI_ARVALID_IN,
   input wire logic        S_AXI_ARREADY_OUT,
   input wire logic [31:0] S_AXI_RDATA_OUT,
   input wire logic [1:0]  S_AXI_RRESP_OUT,
   input wire logic        S_AXI_RVALID_OUT,
   input wire logic        S_AXI_RREADY_IN
);
   default clocking cb @(posedge REF_CLK_IN);
   endclocking
   default disable iff (!RESET_N_IN);

   a_outs_exclusive:
   assert property (!(STAGE_OUTPUT_A_OUT && STAGE_OUTPUT_B_OUT))
      else $error("both stage outputs high");
   a_gap_before_a:
   assert property ($rose(STAGE_OUTPUT_A_OUT) |-> !$past(STAGE_OUTPUT_B_OUT))
      else $error("output a rose without dead time");
   a_gap_before_b:
   assert property ($rose(STAGE_OUTPUT_B_OUT) |-> !$past(STAGE_OUTPUT_A_OUT))
      else $error("output b rose without dead time");
   a_start_idle:
   assert property ($rose(RESET_N_IN) |-> !STAGE_OUTPUT_A_OUT && !STAGE_OUTPUT_B_OUT)
      else $error("outputs active while stage stopped");
   a_write_answer:
   assert property (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_WVALID_IN && S_AXI_WREADY_OUT
                    |-> ##[1:2] S_AXI_BVALID_OUT)
      else $error("write response late");
   a_bresp_stands:
   assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT))
      else $error("write response dropped");
   a_read_answer:
   assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT && !S_AXI_ARREADY_OUT)
      else $error("read answer missing");
   a_rdata_stands:
   assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
      else $error("read data dropped");
   a_unmapped_read:
   assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT && S_AXI_ARADDR_IN[7:2] > 6'h07
                    |=> S_AXI_RRESP_OUT == prfi_pkg::RESP_SLVERR && S_AXI_RDATA_OUT == 32'h0)
      else $error("unmapped read not refused");
endmodule

bind prfi_top prfi_checker u_chk (.REF_CLK_IN, .RESET_N_IN, .STAGE_OUTPUT_A_OUT, .STAGE_OUTPUT_B_OUT,
   .S_AXI_AWADDR_IN, .S_AXI_AWVALID_IN, .S_AXI_AWREADY_OUT, .S_AXI_WVALID_IN, .S_AXI_WREADY_OUT,
   .S_AXI_BRESP_OUT, .S_AXI_BVALID_OUT, .S_AXI_BREADY_IN, .S_AXI_ARADDR_IN, .S_AXI_ARVALID_IN,
   .S_AXI_ARREADY_OUT, .S_AXI_RDATA_OUT, .S_AXI_RRESP_OUT, .S_AXI_RVALID_OUT, .S_AXI_RREADY_IN);

// >>> prfi_input_model.sv
// comparator and fault pin sources facing the stage inputs
`timescale 1ns/1ns
module prfi_input_model (
   input  wire logic       clk_in,
   input  wire logic [1:0] pin_lvl_in,
   input  wire logic [1:0] cmp_lvl_in,
   output logic      [1:0] pin_out,
   output logic      [1:0] cmp_out
);
   // levels move just after an edge, as a synchronised source would
   always_ff @(posedge clk_in)
   begin
      pin_out <= pin_lvl_in;
      cmp_out <= cmp_lvl_in;
   end
endmodule

// >>> pwm_retrigger_fault_inputs_test.sv
// self-checking bench for the stage input block
`timescale 1ns/1ns
module pwm_retrigger_fault_inputs_test;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [1:0]  pin_lvl = 2'h0, cmp_lvl = 2'h0, pin, cmp, bresp, rresp;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, out_a, out_b;
   logic [65:0] rq[$];
   logic [65:0] e;
   logic [1:0]  bq[$], oq[$];
   int          error_cnt = 0, checked = 0, cyc = 0, seed = 32'h803e;

   always #5 clk = ~clk;
   prfi_input_model u_src (.clk_in(clk), .pin_lvl_in(pin_lvl), .cmp_lvl_in(cmp_lvl),
      .pin_out(pin), .cmp_out(cmp));
   prfi_top uut (.REF_CLK_IN(clk), .RESET_N_IN(rst_n), .COMPARATOR_IN(cmp),
      .EXTERNAL_INPUT_PIN_IN(pin), .STAGE_OUTPUT_A_OUT(out_a), .STAGE_OUTPUT_B_OUT(out_b),
      .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
      .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wvalid),
      .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
      .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
      .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
      .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready));

   task automatic stop_test();
      if (error_cnt == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic note(input string what, input logic [33:0] exp, input logic [33:0] got);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // valid is looked at mid-cycle; ready is raised after the next edge and dropped after the one that takes it
   task automatic answer(input bit is_rd);
      do
         @(negedge clk);
      while (!(is_rd ? rvalid : bvalid));
      @(posedge clk);
      {rready, bready} <= is_rd ? 2'b10 : 2'b01;
      @(posedge clk);
      {rready, bready} <= 2'b00;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
      bq.push_back(r);
      awaddr  <= a;
      wdata   <= v;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      do
         @(negedge clk);
      while (!(awready && wready));
      @(posedge clk);
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      answer(1'b0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] m, v, input logic [1:0] r);
      rq.push_back({r, m, v});
      araddr  <= a;
      arvalid <= 1'b1;
      do
         @(negedge clk);
      while (!arready);
      @(posedge clk);
      arvalid <= 1'b0;
      answer(1'b1);
   endtask

   task automatic expect_out(input logic [1:0] v);
      oq.push_back(v);
   endtask

   // a fresh rise only; returns on the edge that ends its first high cycle
   task automatic wait_hi(input bit b);
      for (int i = 0; i < 60 && (b ? out_b : out_a); i++)
         @(negedge clk);
      for (int i = 0; i < 60 && !(b ? out_b : out_a); i++)
         @(negedge clk);
      @(posedge clk);
   endtask

   always @(posedge clk)
   begin
      if (bvalid && bready)
         note("write response", 34'(bq.pop_front()), 34'(bresp));
      if (rvalid && rready)
      begin
         e = rq.pop_front();
         note("read data", {e[65:64], e[31:0]}, {rresp, rdata & e[63:32]});
      end
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         stop_test();
      end
   end

   // looked at mid-cycle, once the launching edge has settled
   always @(negedge clk)
      if (oq.size() > 0)
         note("stage outputs", 34'(oq.pop_front()), 34'({out_a, out_b}));

   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 7; i++)
         rd(8'(4 * i), 32'hffffffff, (i > 0 && i < 5) ? 32'h1 : 32'h0, 2'h0);
      wr(8'h40, 32'hffffffff, prfi_pkg::RESP_SLVERR);
      rd(8'h40, 32'hffffffff, 32'h0, prfi_pkg::RESP_SLVERR);
      for (int i = 1; i < 7; i++)
      begin
         d = $random(seed);
         d[3:0] = d[3:0] % 4'ha; // reserved mode codes are never written
         d = i < 5 ? {20'h0, d[11:0]} : {24'h0, d[7:0]};
         wr(8'(4 * i), d, prfi_pkg::RESP_OKAY);
         rd(8'(4 * i), 32'hffffffff, d, prfi_pkg::RESP_OKAY);
      end
      wr(prfi_pkg::OFS_INCTL_B, 32'h0, prfi_pkg::RESP_OKAY);
      // every polarity, filter and source choice on half a
      for (int i = 0; i < 8; i++)
      begin
         wr(prfi_pkg::OFS_INCTL_A, {24'h0, i[2], 1'b0, i[1], i[0], 4'h0}, 2'h0);
         pin_lvl[0] <= ~i[0];
         cmp_lvl[0] <= ~i[0];
         repeat (8) @(posedge clk);
         if (i[2])
            pin_lvl[0] <= i[0];
         else
            cmp_lvl[0] <= i[0];
         repeat (2) @(posedge clk);
         rd(prfi_pkg::OFS_STATUS, 32'h10000, {15'h0, ~i[1], 16'h0}, 2'h0);
         repeat (8) @(posedge clk);
         rd(prfi_pkg::OFS_STATUS, 32'h10000, 32'h10000, 2'h0);
      end
      pin_lvl <= 2'h0;
      cmp_lvl <= 2'h0;
      for (int i = 1; i < 5; i++)
         wr(8'(4 * i), 32'h4, prfi_pkg::RESP_OKAY);
      wr(prfi_pkg::OFS_INCTL_A, 32'h91, prfi_pkg::RESP_OKAY);
      wr(prfi_pkg::OFS_CTRL, 32'h3, prfi_pkg::RESP_OKAY);
      wait_hi(1'b0);
      pin_lvl[0] <= 1'b1;
      repeat (2) @(posedge clk);
      expect_out(2'b00);
      repeat (20) @(posedge clk);
      expect_out(2'b00);
      pin_lvl[0] <= 1'b0;
      wait_hi(1'b1);
      expect_out(2'b01);
      wr(prfi_pkg::OFS_CTRL, 32'h7, prfi_pkg::RESP_OKAY);
      pin_lvl[0] <= 1'b1;
      repeat (6) @(posedge clk);
      wait_hi(1'b0);
      expect_out(2'b10);
      wr(prfi_pkg::OFS_INCTL_A, 32'h97, prfi_pkg::RESP_OKAY);
      rd(prfi_pkg::OFS_STATUS, 32'h40000, 32'h0, prfi_pkg::RESP_OKAY);
      pin_lvl[0] <= 1'b0;
      wr(prfi_pkg::OFS_CTRL, 32'h7, prfi_pkg::RESP_OKAY);
      rd(prfi_pkg::OFS_STATUS, 32'h40000, 32'h40000, prfi_pkg::RESP_OKAY);
      wr(prfi_pkg::OFS_INCTL_B, 32'hd0, prfi_pkg::RESP_OKAY);
      wait_hi(1'b0);
      pin_lvl[1] <= 1'b1;
      @(posedge clk);
      expect_out(2'b00);
      @(posedge clk);
      stop_test();
   end
endmodule
